// ===== include/spcp_pkg.sv
// Constants, types and baud constant function for the serial/parallel combination port
package spcp_pkg;
	// Register byte addresses
	localparam logic [3:0] ADDR_DATA = 4'h0;
	localparam logic [3:0] ADDR_CMD = 4'h4;
	localparam logic [3:0] ADDR_STATUS = 4'h8;
	localparam logic [3:0] ADDR_PORT = 4'hc;
	// Status bit positions
	localparam int ST_OBF = 0;
	localparam int ST_IBF = 1;
	localparam int ST_SRC0 = 2;
	localparam int ST_SRC1 = 3;
	localparam int ST_TXRDY = 5;
	localparam int ST_FERR = 6;
	localparam int ST_OERR = 7;
	// Command encoding: [7:6] opcode, [5] direction input, [1:0] baud select
	localparam logic [1:0] OP_CONFIG = 2'h1;
	localparam logic [1:0] OP_IO = 2'h2;
	localparam logic [1:0] OP_RSTERR = 2'h3;
	localparam int CMD_DIR = 5;
	// Reference edges per tick, four ticks per bit, two counts short
	localparam logic [7:0] REF_SHORT = 8'h02;
	localparam logic [7:0] DIV_110 = 8'hae;
	localparam logic [7:0] DIV_300 = 8'h40;
	localparam logic [7:0] DIV_600 = 8'h20;
	localparam logic [7:0] DIV_1200 = 8'h10;
	localparam real REF_KHZ = 76.8;
	localparam real CLK_MHZ = 10.0;
	localparam logic [2:0] RX_TICKS = 3'h4;
	localparam logic [7:0] RX_PRESET = 8'h80;
	localparam logic [5:0] TX_END = 6'h28;
	localparam logic [5:0] TX_STOP = 6'h24;
	localparam logic [1:0] TX_MOD_MASK = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		SPCP_DIV_STOP = 2'b00,
		SPCP_DIV_RUN = 2'b01,
		SPCP_DIV_RELOAD = 2'b10
	} spcp_div_e;
	function automatic logic [7:0] spcp_baud_const(input logic [1:0] sel);
		case (sel)
			2'h0: spcp_baud_const = DIV_110;
			2'h1: spcp_baud_const = DIV_300;
			2'h2: spcp_baud_const = DIV_600;
			default: spcp_baud_const = DIV_1200;
		endcase
	endfunction
endpackage

// ===== include/spcp_tick_if.sv
// Tick divider to core control signals
`timescale 1ns/1ps
interface spcp_tick_if;
	logic load;
	logic [7:0] constant;
	logic tick;
	logic reloaded;
	modport ctrl (output load, output constant, input tick, input reloaded);
	modport div (input load, input constant, output tick, output reloaded);
endinterface

// ===== verilog/spcp_tick_div.sv
// Reference-edge tick divider with short-count reload
`timescale 1ns/1ps
module spcp_tick_div
	import spcp_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ref_fall,
	spcp_tick_if.div tk
);
	spcp_div_e state_r, state_nxt;
	logic [7:0] cnt_r, cnt_nxt;
	logic [7:0] const_r, const_nxt;
	logic [1:0] edges_r, edges_nxt;
	logic tick_r, tick_nxt;
	logic rel_r, rel_nxt;

	assign tk.tick = tick_r;
	assign tk.reloaded = rel_r;

	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		const_nxt = const_r;
		edges_nxt = edges_r;
		tick_nxt = 1'b0;
		rel_nxt = 1'b0;
		case (state_r)
			SPCP_DIV_STOP: begin
			end
			SPCP_DIV_RUN: begin
				if (ref_fall) begin
					if (cnt_r <= 8'h01) begin
						tick_nxt = 1'b1;
						edges_nxt = 2'h0;
						state_nxt = SPCP_DIV_RELOAD;
					end else begin
						cnt_nxt = cnt_r - 8'h01;
					end
				end
			end
			SPCP_DIV_RELOAD: begin
				if (ref_fall) begin
					edges_nxt = edges_r + 2'h1;
					if (edges_r == 2'h1) begin
						cnt_nxt = const_r;
						rel_nxt = 1'b1;
						state_nxt = SPCP_DIV_RUN;
					end
				end
			end
			default: state_nxt = SPCP_DIV_STOP;
		endcase
		if (tk.load) begin
			const_nxt = tk.constant;
			cnt_nxt = tk.constant;
			state_nxt = SPCP_DIV_RUN;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= SPCP_DIV_STOP;
			cnt_r <= 8'h00;
			const_r <= 8'h00;
			edges_r <= 2'h0;
			tick_r <= 1'b0;
			rel_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			const_r <= const_nxt;
			edges_r <= edges_nxt;
			tick_r <= tick_nxt;
			rel_r <= rel_nxt;
		end
	end

	property p_reload_after_tick;
		@(posedge aclk) disable iff (!aresetn)
		(tick_r && !tk.load) |-> !rel_r ##1 (state_r == SPCP_DIV_RELOAD);
	endproperty
	a_reload_after_tick: assert property (p_reload_after_tick) else $error("no reload wait");
endmodule

// ===== verilog/spcp_top.sv
// Serial/parallel combination port with AXI4-Lite host access
`timescale 1ns/1ps
module spcp_top
	import spcp_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic rx_data_pin,
	input wire logic ext_ref_clk,
	output logic tx_data_pin,
	output logic tx_ready_irq_pin,
	output logic output_full_irq_pin,
	output logic tick_indicator_pin,
	input wire logic [7:0] par_in,
	output logic [7:0] par_out,
	output logic [7:0] par_oe
);
	spcp_tick_if tk ();

	// Pin synchronisers
	logic [1:0] rx_s_r, ref_s_r;
	logic ref_d_r;
	logic [7:0] pin1_r, pin2_r;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_s_r <= 2'b11;
			ref_s_r <= 2'b00;
			ref_d_r <= 1'b0;
			pin1_r <= 8'h00;
			pin2_r <= 8'h00;
		end else begin
			rx_s_r <= {rx_s_r[0], rx_data_pin};
			ref_s_r <= {ref_s_r[0], ext_ref_clk};
			ref_d_r <= ref_s_r[1];
			pin1_r <= par_in;
			pin2_r <= pin1_r;
		end
	end
	logic rxd;
	logic ref_fall;
	assign rxd = rx_s_r[1];
	assign ref_fall = ref_d_r & ~ref_s_r[1];

	spcp_tick_div u_div (
		.aclk(aclk),
		.aresetn(aresetn),
		.ref_fall(ref_fall),
		.tk(tk)
	);

	// Host buffers and flags
	logic [7:0] hw_buf_r, hw_buf_nxt;
	logic ibf_r, ibf_nxt, cmd_flag_r, cmd_flag_nxt;
	logic [7:0] hr_buf_r, hr_buf_nxt;
	logic obf_r, obf_nxt;
	logic src0_r, src0_nxt, src1_r, src1_nxt;
	logic ferr_st_r, ferr_st_nxt, oerr_st_r, oerr_st_nxt;
	logic dir_in_r, dir_in_nxt, io_pend_r, io_pend_nxt;
	logic [7:0] par_out_r, par_out_nxt, par_oe_r, par_oe_nxt;
	logic tk_load_r, tk_load_nxt;
	logic [7:0] tk_const_r, tk_const_nxt;
	// Receiver state
	logic rx_flag_r, rx_flag_nxt, rx_good_r, rx_good_nxt, rx_fin_r, rx_fin_nxt;
	logic rx_rdy_r, rx_rdy_nxt, rx_ferr_r, rx_ferr_nxt, rx_oerr_r, rx_oerr_nxt;
	logic [7:0] rx_hold_r, rx_hold_nxt, rx_sh_r, rx_sh_nxt;
	logic [2:0] rx_cnt_r, rx_cnt_nxt;
	// Transmitter state
	logic tx_act_r, tx_act_nxt, tx_req_r, tx_req_nxt, tx_pipe_r, tx_pipe_nxt;
	logic tx_start_r, tx_start_nxt, tx_rdy_r, tx_rdy_nxt;
	logic [7:0] tx_hold_r, tx_hold_nxt, tx_sh_r, tx_sh_nxt;
	logic [5:0] tx_cnt_r, tx_cnt_nxt;
	logic txd_r, txd_nxt, tick_pin_r, tick_pin_nxt;
	// Bus
	logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt, bvalid_r, bvalid_nxt;
	logic [3:0] awaddr_r, awaddr_nxt;
	logic [7:0] wdata_r, wdata_nxt;
	logic wlane_r, wlane_nxt;
	logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic rvalid_r, rvalid_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic awready_r, awready_nxt, wready_r, wready_nxt, arready_r, arready_nxt;

	logic [7:0] status;
	assign status = {oerr_st_r, ferr_st_r, tx_rdy_r, 1'b0, src1_r, src0_r, ibf_r, obf_r};
	assign tk.load = tk_load_r;
	assign tk.constant = tk_const_r;

	always_comb begin
		aw_got_nxt = aw_got_r;
		w_got_nxt = w_got_r;
		awaddr_nxt = awaddr_r;
		wdata_nxt = wdata_r;
		wlane_nxt = wlane_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		rvalid_nxt = rvalid_r;
		rresp_nxt = rresp_r;
		rdata_nxt = rdata_r;
		hw_buf_nxt = hw_buf_r;
		ibf_nxt = ibf_r;
		cmd_flag_nxt = cmd_flag_r;
		hr_buf_nxt = hr_buf_r;
		obf_nxt = obf_r;
		src0_nxt = src0_r;
		src1_nxt = src1_r;
		ferr_st_nxt = ferr_st_r;
		oerr_st_nxt = oerr_st_r;
		dir_in_nxt = dir_in_r;
		io_pend_nxt = io_pend_r;
		par_out_nxt = par_out_r;
		par_oe_nxt = par_oe_r;
		tk_load_nxt = 1'b0;
		tk_const_nxt = tk_const_r;
		rx_flag_nxt = rx_flag_r;
		rx_good_nxt = rx_good_r;
		rx_fin_nxt = rx_fin_r;
		rx_rdy_nxt = rx_rdy_r;
		rx_ferr_nxt = rx_ferr_r;
		rx_oerr_nxt = rx_oerr_r;
		rx_hold_nxt = rx_hold_r;
		rx_sh_nxt = rx_sh_r;
		rx_cnt_nxt = rx_cnt_r;
		tx_act_nxt = tx_act_r;
		tx_req_nxt = tx_req_r;
		tx_pipe_nxt = tx_pipe_r;
		tx_start_nxt = tx_start_r;
		tx_rdy_nxt = tx_rdy_r;
		tx_hold_nxt = tx_hold_r;
		tx_sh_nxt = tx_sh_r;
		tx_cnt_nxt = tx_cnt_r;
		txd_nxt = txd_r;
		tick_pin_nxt = tick_pin_r;

		// Write channel capture, then commit once both halves are held
		if (s_axi_awvalid && !aw_got_r && !bvalid_r) begin
			aw_got_nxt = 1'b1;
			awaddr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_got_r && !bvalid_r) begin
			w_got_nxt = 1'b1;
			wdata_nxt = s_axi_wdata[7:0];
			wlane_nxt = s_axi_wstrb[0];
		end
		if (aw_got_r && w_got_r) begin
			aw_got_nxt = 1'b0;
			w_got_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = RESP_OKAY;
			if (awaddr_r == ADDR_DATA || awaddr_r == ADDR_CMD) begin
				// Busy buffer drops the write and reports it
				if (ibf_r) begin
					bresp_nxt = RESP_SLVERR;
				end else if (wlane_r) begin
					hw_buf_nxt = wdata_r;
					ibf_nxt = 1'b1;
					cmd_flag_nxt = (awaddr_r == ADDR_CMD);
				end
			end else if (awaddr_r != ADDR_STATUS && awaddr_r != ADDR_PORT) begin
				bresp_nxt = RESP_SLVERR;
			end
		end
		if (bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
		// Read channel; reading the data buffer frees it
		if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end else if (s_axi_arvalid && !rvalid_r) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = RESP_OKAY;
			rdata_nxt = 32'h0000_0000;
			case (s_axi_araddr)
				ADDR_DATA: begin
					rdata_nxt = {24'h00_0000, hr_buf_r};
					obf_nxt = 1'b0;
				end
				ADDR_STATUS: rdata_nxt = {24'h00_0000, status};
				ADDR_PORT: rdata_nxt = {24'h00_0000, pin2_r};
				ADDR_CMD: rdata_nxt = 32'h0000_0000;
				default: rresp_nxt = RESP_SLVERR;
			endcase
		end
		// Ready outputs registered from the settled next state
		awready_nxt = !aw_got_nxt && !bvalid_nxt;
		wready_nxt = !w_got_nxt && !bvalid_nxt;
		arready_nxt = !rvalid_nxt;

		if (ibf_r) begin
			ibf_nxt = 1'b0;
			if (cmd_flag_r) begin
				case (hw_buf_r[7:6])
					OP_CONFIG: begin
						dir_in_nxt = hw_buf_r[CMD_DIR];
						tk_const_nxt = spcp_baud_const(hw_buf_r[1:0]) - REF_SHORT;
						tk_load_nxt = 1'b1;
						if (hw_buf_r[CMD_DIR]) begin
							par_out_nxt = 8'hff;
							par_oe_nxt = 8'h00;
						end else begin
							par_oe_nxt = 8'hff;
						end
					end
					OP_IO: io_pend_nxt = 1'b1;
					OP_RSTERR: begin
						ferr_st_nxt = 1'b0;
						oerr_st_nxt = 1'b0;
					end
					default: begin
					end
				endcase
			end else if (io_pend_r) begin
				par_out_nxt = hw_buf_r;
				io_pend_nxt = 1'b0;
			end else begin
				tx_hold_nxt = hw_buf_r;
				tx_rdy_nxt = 1'b0;
				tx_req_nxt = 1'b1;
			end
		end else if (!obf_r && !(s_axi_arvalid && !rvalid_r && s_axi_araddr == ADDR_DATA)) begin
			if (rx_rdy_r) begin
				hr_buf_nxt = rx_hold_r;
				obf_nxt = 1'b1;
				src0_nxt = 1'b1;
				src1_nxt = 1'b1;
				ferr_st_nxt = ferr_st_r | rx_ferr_r;
				oerr_st_nxt = oerr_st_r | rx_oerr_r;
				rx_rdy_nxt = 1'b0;
				rx_oerr_nxt = 1'b0;
			end else if (io_pend_r && dir_in_r) begin
				hr_buf_nxt = pin2_r;
				obf_nxt = 1'b1;
				src0_nxt = 1'b0;
				src1_nxt = 1'b1;
				io_pend_nxt = 1'b0;
			end
		end

		if (tk.reloaded) begin
			tick_pin_nxt = ~tick_pin_r;
		end
		if (tk.tick) begin
			txd_nxt = tx_pipe_r;
			// Receiver
			if (!rx_flag_r) begin
				rx_flag_nxt = ~rxd;
			end else if (!rx_good_r) begin
				if (rxd) begin
					rx_flag_nxt = 1'b0;
				end else begin
					rx_good_nxt = 1'b1;
					rx_cnt_nxt = RX_TICKS;
					rx_sh_nxt = RX_PRESET;
				end
			end else if (rx_cnt_r != 3'h1) begin
				rx_cnt_nxt = rx_cnt_r - 3'h1;
			end else begin
				rx_cnt_nxt = RX_TICKS;
				if (!rx_fin_r) begin
					rx_sh_nxt = {rxd, rx_sh_r[7:1]};
					rx_fin_nxt = rx_sh_r[0];
				end else begin
					rx_ferr_nxt = ~rxd;
					if (rx_rdy_r && !(rx_rdy_nxt == 1'b0)) begin
						rx_oerr_nxt = 1'b1;
					end
					rx_hold_nxt = rx_sh_r;
					rx_rdy_nxt = 1'b1;
					rx_flag_nxt = 1'b0;
					rx_good_nxt = 1'b0;
					rx_fin_nxt = 1'b0;
				end
			end
			// Transmitter
			if (tx_start_r) begin
				tx_start_nxt = 1'b0;
				tx_cnt_nxt = 6'h00;
			end else if (((tx_cnt_r + 6'h01) & {4'h0, TX_MOD_MASK}) != 6'h00) begin
				tx_cnt_nxt = tx_cnt_r + 6'h01;
			end else begin
				tx_cnt_nxt = tx_cnt_r + 6'h01;
				if (!tx_act_r) begin
					if (tx_req_r) begin
						tx_sh_nxt = tx_hold_r;
						tx_req_nxt = 1'b0;
						tx_act_nxt = 1'b1;
						tx_start_nxt = 1'b1;
						tx_pipe_nxt = 1'b0;
					end
					if (!(ibf_r && !cmd_flag_r && !io_pend_r)) begin
						tx_rdy_nxt = 1'b1;
					end
				end else if (tx_cnt_r + 6'h01 == TX_END) begin
					tx_act_nxt = 1'b0;
				end else if (tx_cnt_r + 6'h01 == TX_STOP) begin
					tx_pipe_nxt = 1'b1;
				end else begin
					tx_pipe_nxt = tx_sh_r[0];
					tx_sh_nxt = {1'b1, tx_sh_r[7:1]};
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			awaddr_r <= 4'h0;
			wdata_r <= 8'h00;
			wlane_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			rvalid_r <= 1'b0;
			rresp_r <= RESP_OKAY;
			rdata_r <= 32'h0000_0000;
			awready_r <= 1'b1;
			wready_r <= 1'b1;
			arready_r <= 1'b1;
			hw_buf_r <= 8'h00;
			ibf_r <= 1'b0;
			cmd_flag_r <= 1'b0;
			hr_buf_r <= 8'h00;
			obf_r <= 1'b0;
			src0_r <= 1'b0;
			src1_r <= 1'b0;
			ferr_st_r <= 1'b0;
			oerr_st_r <= 1'b0;
			dir_in_r <= 1'b1;
			io_pend_r <= 1'b0;
			par_out_r <= 8'hff;
			par_oe_r <= 8'h00;
			tk_load_r <= 1'b0;
			tk_const_r <= 8'h00;
			rx_flag_r <= 1'b0;
			rx_good_r <= 1'b0;
			rx_fin_r <= 1'b0;
			rx_rdy_r <= 1'b0;
			rx_ferr_r <= 1'b0;
			rx_oerr_r <= 1'b0;
			rx_hold_r <= 8'h00;
			rx_sh_r <= 8'h00;
			rx_cnt_r <= 3'h0;
			tx_act_r <= 1'b0;
			tx_req_r <= 1'b0;
			tx_pipe_r <= 1'b1;
			tx_start_r <= 1'b0;
			tx_rdy_r <= 1'b1;
			tx_hold_r <= 8'h00;
			tx_sh_r <= 8'h00;
			tx_cnt_r <= 6'h00;
			txd_r <= 1'b1;
			tick_pin_r <= 1'b0;
		end else begin
			aw_got_r <= aw_got_nxt;
			w_got_r <= w_got_nxt;
			awaddr_r <= awaddr_nxt;
			wdata_r <= wdata_nxt;
			wlane_r <= wlane_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rresp_r <= rresp_nxt;
			rdata_r <= rdata_nxt;
			awready_r <= awready_nxt;
			wready_r <= wready_nxt;
			arready_r <= arready_nxt;
			hw_buf_r <= hw_buf_nxt;
			ibf_r <= ibf_nxt;
			cmd_flag_r <= cmd_flag_nxt;
			hr_buf_r <= hr_buf_nxt;
			obf_r <= obf_nxt;
			src0_r <= src0_nxt;
			src1_r <= src1_nxt;
			ferr_st_r <= ferr_st_nxt;
			oerr_st_r <= oerr_st_nxt;
			dir_in_r <= dir_in_nxt;
			io_pend_r <= io_pend_nxt;
			par_out_r <= par_out_nxt;
			par_oe_r <= par_oe_nxt;
			tk_load_r <= tk_load_nxt;
			tk_const_r <= tk_const_nxt;
			rx_flag_r <= rx_flag_nxt;
			rx_good_r <= rx_good_nxt;
			rx_fin_r <= rx_fin_nxt;
			rx_rdy_r <= rx_rdy_nxt;
			rx_ferr_r <= rx_ferr_nxt;
			rx_oerr_r <= rx_oerr_nxt;
			rx_hold_r <= rx_hold_nxt;
			rx_sh_r <= rx_sh_nxt;
			rx_cnt_r <= rx_cnt_nxt;
			tx_act_r <= tx_act_nxt;
			tx_req_r <= tx_req_nxt;
			tx_pipe_r <= tx_pipe_nxt;
			tx_start_r <= tx_start_nxt;
			tx_rdy_r <= tx_rdy_nxt;
			tx_hold_r <= tx_hold_nxt;
			tx_sh_r <= tx_sh_nxt;
			tx_cnt_r <= tx_cnt_nxt;
			txd_r <= txd_nxt;
			tick_pin_r <= tick_pin_nxt;
		end
	end

	assign tx_data_pin = txd_r;
	assign tx_ready_irq_pin = tx_rdy_r;
	assign output_full_irq_pin = obf_r;
	assign tick_indicator_pin = tick_pin_r;
	assign par_out = par_out_r;
	assign par_oe = par_oe_r;
	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	property p_false_start;
		@(posedge aclk) disable iff (!aresetn)
		(tk.tick && rx_flag_r && !rx_good_r && rxd) |=> !rx_flag_r;
	endproperty
	a_false_start: assert property (p_false_start) else $error("false start kept");
	property p_preset;
		@(posedge aclk) disable iff (!aresetn)
		(tk.tick && rx_flag_r && !rx_good_r && !rxd) |=> (rx_sh_r == RX_PRESET && rx_cnt_r == RX_TICKS);
	endproperty
	a_preset: assert property (p_preset) else $error("deserializer not preset");
	property p_idle_sample;
		@(posedge aclk) disable iff (!aresetn)
		(tk.tick && !rx_flag_r && !rxd) |=> rx_flag_r;
	endproperty
	a_idle_sample: assert property (p_idle_sample) else $error("start not seen");
	property p_frame_err;
		@(posedge aclk) disable iff (!aresetn)
		(tk.tick && rx_fin_r && rx_cnt_r == 3'h1) |=> (rx_ferr_r == !$past(rxd) && rx_rdy_r);
	endproperty
	a_frame_err: assert property (p_frame_err) else $error("stop check wrong");
	property p_txd_pipe;
		@(posedge aclk) disable iff (!aresetn)
		tk.tick |=> (txd_r == $past(tx_pipe_r));
	endproperty
	a_txd_pipe: assert property (p_txd_pipe) else $error("line not from pipeline");
	property p_tx_write;
		@(posedge aclk) disable iff (!aresetn)
		(ibf_r && !cmd_flag_r && !io_pend_r) |=> (tx_req_r && !tx_rdy_r);
	endproperty
	a_tx_write: assert property (p_tx_write) else $error("transmit write lost");
	property p_par_out;
		@(posedge aclk) disable iff (!aresetn)
		(ibf_r && !cmd_flag_r && io_pend_r) |=> (par_out_r == $past(hw_buf_r) && !io_pend_r);
	endproperty
	a_par_out: assert property (p_par_out) else $error("parallel byte lost");
	property p_tick_toggle;
		@(posedge aclk) disable iff (!aresetn)
		tk.reloaded |=> (tick_pin_r != $past(tick_pin_r));
	endproperty
	a_tick_toggle: assert property (p_tick_toggle) else $error("indicator not toggled");
	property p_rsterr;
		@(posedge aclk) disable iff (!aresetn)
		(ibf_r && cmd_flag_r && hw_buf_r[7:6] == OP_RSTERR) |=> (!ferr_st_r && !oerr_st_r);
	endproperty
	a_rsterr: assert property (p_rsterr) else $error("errors not cleared");
endmodule

// ===== bench/spcp_line_model.sv
// Serial line peer and reference source for the combination port
`timescale 1ns/1ps
module spcp_line_model #(
	parameter int REF_HALF_NS = 500,
	parameter int BIT_NS = 64000
) (
	output logic ext_ref_clk,
	output logic rx_data_pin,
	input wire logic tx_data_pin,
	output logic [7:0] tx_byte,
	output int tx_count
);
	logic rx_level = 1'b1;
	assign rx_data_pin = rx_level;
	initial begin
		ext_ref_clk = 1'b1;
		forever #(REF_HALF_NS) ext_ref_clk = ~ext_ref_clk;
	end
	initial begin
		tx_byte = 8'h00;
		tx_count = 0;
		forever begin
			@(negedge tx_data_pin);
			#(BIT_NS / 2);
			for (int i = 0; i < 8; i++) begin
				#(BIT_NS);
				tx_byte[i] = tx_data_pin;
			end
			#(BIT_NS);
			if (tx_data_pin) tx_count++;
		end
	end
	task automatic send(input logic [7:0] b);
		rx_level = 1'b0;
		#(BIT_NS);
		for (int i = 0; i < 8; i++) begin
			rx_level = b[i];
			#(BIT_NS);
		end
		rx_level = 1'b1;
		#(2 * BIT_NS);
	endtask
	// space spanning one tick only; call right after the indicator toggles
	task automatic glitch;
		#(BIT_NS / 8);
		rx_level = 1'b0;
		#(BIT_NS * 3 / 16);
		rx_level = 1'b1;
	endtask
endmodule

// ===== bench/serial_parallel_combo_port_bench.sv
// Self-checking bench for the serial/parallel combination port
`timescale 1ns/1ps
module serial_parallel_combo_port_bench import spcp_pkg::*;;
	logic aclk = 1'b0;
	logic aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic rx_data_pin, ext_ref_clk, tx_data_pin, tx_ready_irq_pin;
	logic output_full_irq_pin, tick_indicator_pin;
	logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, v;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [7:0] par_in, par_out, par_oe, tx_byte;
	int tx_count;
	int n_errors = 0;
	int num_checks = 0;
	realtime t0;
	always #50 aclk = ~aclk;
	spcp_top u_spcp_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_data_pin, .ext_ref_clk, .tx_data_pin,
		.tx_ready_irq_pin, .output_full_irq_pin, .tick_indicator_pin, .par_in, .par_out,
		.par_oe);
	// Faster reference keeps frames short; bit time is 64 reference periods
	spcp_line_model #(.REF_HALF_NS(500), .BIT_NS(64000)) u_spcp_line_model (.ext_ref_clk,
		.rx_data_pin, .tx_data_pin, .tx_byte, .tx_count);
	task automatic close_out;
		if (n_errors == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		logic ta, tw, tb;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		tb = 1'b0;
		while (!tb) begin
			@(negedge aclk);
			ta = s_axi_awvalid & s_axi_awready;
			tw = s_axi_wvalid & s_axi_wready;
			tb = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		logic tr, td;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		td = 1'b0;
		while (!td) begin
			@(negedge aclk);
			tr = s_axi_arvalid & s_axi_arready;
			td = s_axi_rvalid;
			v = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (tr) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
	endtask
	task automatic rdc(input logic [3:0] a, input logic [31:0] e);
		rd(a);
		chk(v, e);
	endtask
	initial begin
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		s_axi_awaddr = 4'h0;
		s_axi_araddr = 4'h0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		par_in = 8'h5a;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rdc(ADDR_STATUS, 32'h20);
		chk({21'h0, tx_data_pin, tx_ready_irq_pin, output_full_irq_pin, par_oe}, 32'h600);
		rd(4'h2);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		wr(ADDR_CMD, 8'h63);
		@(negedge aclk);
		chk({16'h0, par_out, par_oe}, 32'hff00);
		@(tick_indicator_pin);
		t0 = $realtime;
		@(tick_indicator_pin);
		t0 = $realtime - t0 - 16000.0;
		chk({31'h0, t0 < 250.0 && t0 > -250.0}, 32'h1);
		wr(ADDR_DATA, 8'ha5);
		rdc(ADDR_STATUS, 32'h00);
		wait (tx_count == 1);
		chk({24'h0, tx_byte}, 32'ha5);
		chk({31'h0, tx_ready_irq_pin}, 32'h1);
		u_spcp_line_model.send(8'h11);
		u_spcp_line_model.send(8'h22);
		u_spcp_line_model.send(8'h33);
		rdc(ADDR_STATUS, 32'h2d);
		rdc(ADDR_DATA, 32'h11);
		rdc(ADDR_STATUS, 32'had);
		rdc(ADDR_DATA, 32'h33);
		wr(ADDR_CMD, 8'hc0);
		rd(ADDR_STATUS);
		chk(v & 32'hf3, 32'h20);
		@(tick_indicator_pin);
		u_spcp_line_model.glitch;
		repeat (7000) @(posedge aclk);
		rd(ADDR_STATUS);
		chk(v & 32'hf3, 32'h20);
		wr(ADDR_CMD, 8'h80);
		wait (output_full_irq_pin);
		rdc(ADDR_STATUS, 32'h29);
		rdc(ADDR_DATA, 32'h5a);
		wr(ADDR_CMD, 8'h43);
		wr(ADDR_CMD, 8'h80);
		wr(ADDR_DATA, 8'h96);
		repeat (4) @(posedge aclk);
		chk({16'h0, par_out, par_oe}, 32'h96ff);
		rd(ADDR_STATUS);
		chk(v & 32'hf3, 32'h20);
		wr(ADDR_CMD, 8'h63);
		@(negedge aclk);
		chk({16'h0, par_out, par_oe}, 32'hff00);
		close_out;
	end
	initial begin
		#6000000;
		n_errors++;
		close_out;
	end
endmodule
